// [src/srbd_top.sv]
// sdram mode load, refresh timer, bank decode and address multiplexer
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - a write to mode base plus X loads X; written data is ignored
// - the mode value goes out on the sdram address pins
// - mode setting is ten bits, write only, never read back
// - control/status is 16 bits, resets zero, bits 15:8 read zero
// - match flag bit 7 sets when counter equals constant
// - writing 0 to the match flag clears it
// - writing 1 to the match flag leaves it unchanged
// - prescale select: stop, then divide by 4 up to 4096
// - 16-bit counter, read/write, counts each prescaled tick, resets zero
// - refresh enabled and auto mode: match starts a refresh cycle
// - constant is compared against the low 8 counter bits
// - constant register is 16 bits, read/write, resets zero
// - bank selected when address 31:24 masked equals base
// - bank base field sits at bits 15:8, resets 0x20
// - bank mask field is 8 bits, resets 0xF8
// - bank window bits 31:16 read zero and ignore writes
// - address pins carry row, column, bank from width fields
// - no bank activate for the refresh cycle time after refresh
module srbd_top
  import srbd_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [31:0] phys_addr_in,
  input wire logic row_phase_in,
  input wire logic col_a10_in,
  output logic [31:0] reg_rdata_out,
  output logic [14:0] sdram_addr_out,
  output logic mode_cmd_out,
  output logic refresh_cmd_out,
  output logic activate_block_out,
  output logic bank_sel_out
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic cmf_q;
  logic [2:0] cks_q;
  logic [15:0] count_q;
  logic [15:0] constant_q;
  logic [7:0] base_q;
  logic [7:0] mask_q;
  logic [10:0] memctl_q;
  logic [11:0] prescale_q;
  logic [3:0] guard_q;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic hit_cs = (reg_addr_in == SRBD_OFS_CTRL_STATUS);
  wire logic hit_cnt = (reg_addr_in == SRBD_OFS_COUNT);
  wire logic hit_cor = (reg_addr_in == SRBD_OFS_CONSTANT);
  wire logic hit_bank = (reg_addr_in == SRBD_OFS_BANK_WINDOW);
  wire logic hit_mc = (reg_addr_in == SRBD_OFS_MEM_CONTROL);
  wire logic hit_mode =
    ((reg_addr_in & SRBD_MODE_WIN_MASK) == SRBD_MODE_BASE);
  wire logic wr_cs = reg_write_in && hit_cs;
  wire logic wr_cnt = reg_write_in && hit_cnt;
  wire logic wr_cor = reg_write_in && hit_cor;
  wire logic wr_bank = reg_write_in && hit_bank;
  wire logic wr_mc = reg_write_in && hit_mc;
  // mode value rides on the address; data lines are not looked at
  wire logic wr_mode = reg_write_in && hit_mode;
  wire logic [9:0] mode_val = reg_addr_in[SRBD_MODE_W-1:0];

  // ----------------------------------------------------------------
  // memory control fields
  // ----------------------------------------------------------------
  wire logic ref_enable = memctl_q[SRBD_MC_REN_BIT];
  wire logic ref_mode = memctl_q[SRBD_MC_REFRESH_MODE_SELECT_BIT];
  wire logic [2:0] trc_f = memctl_q[SRBD_MC_TRC_LSB +: 3];
  wire logic [2:0] col_f = memctl_q[SRBD_MC_COL_LSB +: 3];
  wire logic [1:0] row_f = memctl_q[SRBD_MC_ROW_LSB +: 2];
  wire logic two_bank_bits = memctl_q[SRBD_MC_BANK2_BIT];

  // ----------------------------------------------------------------
  // refresh timer
  // ----------------------------------------------------------------
  // prescaler runs free so a select change takes effect at once
  wire logic [11:0] div_mask = srbd_div_mask(cks_q);
  wire logic tick = (cks_q != SRBD_CKS_STOP) &&
    ((prescale_q & div_mask) == div_mask);
  // only the low byte takes part in the compare
  wire logic match = (count_q[7:0] == constant_q[7:0]);
  // one event per interval: compare is sampled on the counting tick
  wire logic match_evt = tick && match;
  wire logic refresh_start = match_evt && ref_enable &&
    (ref_mode == SRBD_REFRESH_MODE_SELECT_AUTO);
  wire logic [15:0] count_d = wr_cnt ? reg_wdata_in[15:0] :
    match_evt ? SRBD_RST_COUNT :
    tick ? count_q + 16'h0001 : count_q;
  // set beats a same-cycle clear; writing 1 keeps the flag
  wire logic cmf_d = match_evt ? 1'b1 :
    (wr_cs && !reg_wdata_in[SRBD_CMF_BIT]) ? 1'b0 :
    cmf_q;

  // prescaler and counter
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      prescale_q <= 12'h000;
      count_q <= SRBD_RST_COUNT;
    end else begin
      prescale_q <= prescale_q + 12'h001;
      count_q <= count_d;
    end
  end

  // control/status and constant
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cmf_q <= SRBD_RST_CTRL_STATUS[SRBD_CMF_BIT];
      cks_q <= SRBD_RST_CTRL_STATUS[2:0];
      constant_q <= SRBD_RST_CONSTANT;
    end else begin
      cmf_q <= cmf_d;
      if (wr_cs) begin
        cks_q <= reg_wdata_in[SRBD_CKS_LSB +: 3];
      end
      if (wr_cor) begin
        constant_q <= reg_wdata_in[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bank window and memory control
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      base_q <= SRBD_RST_BASE;
      mask_q <= SRBD_RST_MASK;
      memctl_q <= SRBD_RST_MEM_CONTROL;
    end else begin
      if (wr_bank) begin
        base_q <= reg_wdata_in[SRBD_BASE_LSB +: 8];
        mask_q <= reg_wdata_in[SRBD_MASK_LSB +: 8];
      end
      if (wr_mc) begin
        memctl_q <= reg_wdata_in[SRBD_MC_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux; mode window and unmapped addresses read zero
  // ----------------------------------------------------------------
  wire logic [31:0] rd_cs = {24'h000000, cmf_q, 4'h0, cks_q};
  wire logic [31:0] rd_bank = {16'h0000, base_q, mask_q};
  wire logic [31:0] rd_mux =
    hit_cs ? rd_cs :
    hit_cnt ? {16'h0000, count_q} :
    hit_cor ? {16'h0000, constant_q} :
    hit_bank ? rd_bank :
    hit_mc ? {21'h000000, memctl_q} :
    32'h00000000;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= reg_read_in ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // refresh command and activate guard
  // ----------------------------------------------------------------
  // guard length is 2*field+1 cycles: 1, 3, ... 15
  wire logic [3:0] trc_cycles = {trc_f, 1'b1};
  wire logic [3:0] guard_d = refresh_start ? trc_cycles :
    (guard_q != 4'h0) ? guard_q - 4'h1 : 4'h0;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      guard_q <= 4'h0;
      refresh_cmd_out <= 1'b0;
      activate_block_out <= 1'b0;
    end else begin
      guard_q <= guard_d;
      refresh_cmd_out <= refresh_start;
      activate_block_out <= (guard_d != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // bank decode and address multiplexer
  // ----------------------------------------------------------------
  // overlap between banks is software's problem; one window is decoded
  wire logic bank_hit =
    ((phys_addr_in[31:24] & mask_q) == base_q);
  // row starts above the column bits and the byte lanes
  wire logic [4:0] row_shift = 5'(SRBD_COL_BASE_BITS + SRBD_BYTE_SHIFT)
    + {2'b00, col_f};
  wire logic [4:0] bank_shift = row_shift + 5'(SRBD_ROW_BASE_BITS)
    + {3'b000, row_f};
  wire logic [31:0] row_src = phys_addr_in >> row_shift;
  wire logic [31:0] bank_src = phys_addr_in >> bank_shift;
  wire logic [1:0] bank_bits = {two_bank_bits & bank_src[1], bank_src[0]};
  wire logic [12:0] col_bits = {phys_addr_in[13:12], col_a10_in,
    phys_addr_in[11:2]};
  wire logic [12:0] row_bits = row_src[SRBD_ROW_OUT_W-1:0];
  wire logic [14:0] mux_addr =
    {bank_bits, row_phase_in ? row_bits : col_bits};

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      sdram_addr_out <= 15'h0000;
      mode_cmd_out <= 1'b0;
      bank_sel_out <= 1'b0;
    end else begin
      sdram_addr_out <= wr_mode ? {5'h00, mode_val} :
        mux_addr;
      mode_cmd_out <= wr_mode;
      bank_sel_out <= bank_hit;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  mode_load_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (reg_write_in && hit_mode) |=> mode_cmd_out &&
      (sdram_addr_out == {5'h00, $past(reg_addr_in[9:0])}))
    else $error("mode value not placed on address pins");

  mode_pins_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      mode_cmd_out |-> (sdram_addr_out[14:10] == 5'h00))
    else $error("mode command with high address bits set");

  cs_reserved_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (reg_read_in && hit_cs) |=> (reg_rdata_out[31:8] == 24'h000000)
      && (reg_rdata_out[7] == $past(cmf_q)))
    else $error("control/status read shows reserved bits");

  flag_set_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (tick && count_q[7:0] == constant_q[7:0]) |=> cmf_q)
    else $error("match flag not set on compare match");

  flag_clear_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (wr_cs && !reg_wdata_in[7] && !match_evt) |=> !cmf_q)
    else $error("match flag not cleared by write of zero");

  flag_keep_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (wr_cs && reg_wdata_in[7] && !match_evt) |=> $stable(cmf_q))
    else $error("writing one changed the match flag");

  count_stop_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (cks_q == 3'h0 && !wr_cnt) |=> $stable(count_q))
    else $error("counter moved while prescaler stopped");

  count_step_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (cks_q == 3'h1 && !wr_cnt && !match)[*4] |=>
      (count_q != $past(count_q, 4)))
    else $error("counter did not advance at divide by four");

  refresh_go_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (match_evt && ref_enable && !ref_mode) |=> refresh_cmd_out
      ##1 !refresh_cmd_out)
    else $error("refresh command missing or longer than a cycle");

  count_restart_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (match_evt && !wr_cnt) |=> (count_q == 16'h0000))
    else $error("counter did not restart after match");

  bank_decode_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      ##1 (bank_sel_out ==
      (($past(phys_addr_in[31:24]) & $past(mask_q)) == $past(base_q))))
    else $error("bank select disagrees with base and mask");

  bank_reserved_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (reg_read_in && hit_bank) |=> (reg_rdata_out[31:16] == 16'h0000))
    else $error("bank window upper bits not zero");

  activate_guard_a:
    assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (refresh_cmd_out && trc_f == 3'h1 && !refresh_start) |->
      activate_block_out ##1 activate_block_out ##1 activate_block_out
      ##1 !activate_block_out)
    else $error("activate guard not three cycles long");

endmodule

`default_nettype wire

// [src/srbd_pkg.sv]
// constants for the sdram refresh, mode, bank decode and address mux block
package srbd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam int SRBD_ADDR_W = 16;
  localparam logic [15:0] SRBD_OFS_CTRL_STATUS = 16'h0000;
  localparam logic [15:0] SRBD_OFS_COUNT = 16'h0004;
  localparam logic [15:0] SRBD_OFS_CONSTANT = 16'h0008;
  localparam logic [15:0] SRBD_OFS_BANK_WINDOW = 16'h000C;
  localparam logic [15:0] SRBD_OFS_MEM_CONTROL = 16'h0010;
  localparam logic [15:0] SRBD_MODE_BASE = 16'hA000;
  localparam logic [15:0] SRBD_MODE_WIN_MASK = 16'hFC00;
  localparam int SRBD_MODE_W = 10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SRBD_CMF_BIT = 7;
  localparam int SRBD_CKS_LSB = 0;
  localparam int SRBD_BASE_LSB = 8;
  localparam int SRBD_MASK_LSB = 0;
  localparam int SRBD_MC_REN_BIT = 0;
  localparam int SRBD_MC_REFRESH_MODE_SELECT_BIT = 1;
  localparam int SRBD_MC_TRC_LSB = 2;
  localparam int SRBD_MC_COL_LSB = 5;
  localparam int SRBD_MC_ROW_LSB = 8;
  localparam int SRBD_MC_BANK2_BIT = 10;
  localparam int SRBD_MC_W = 11;
  localparam int SRBD_COL_A10_BIT = 10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SRBD_RST_CTRL_STATUS = 16'h0000;
  localparam logic [15:0] SRBD_RST_COUNT = 16'h0000;
  localparam logic [15:0] SRBD_RST_CONSTANT = 16'h0000;
  localparam logic [7:0] SRBD_RST_BASE = 8'h20;
  localparam logic [7:0] SRBD_RST_MASK = 8'hF8;
  localparam logic [10:0] SRBD_RST_MEM_CONTROL = 11'h000;

  // ----------------------------------------------------------------
  // refresh prescaler and address mux constants
  // ----------------------------------------------------------------
  localparam logic [2:0] SRBD_CKS_STOP = 3'h0;
  localparam int SRBD_PRESCALE_W = 12;
  localparam logic SRBD_REFRESH_MODE_SELECT_AUTO = 1'b0;
  localparam int SRBD_COL_BASE_BITS = 8;
  localparam int SRBD_ROW_BASE_BITS = 11;
  localparam int SRBD_BYTE_SHIFT = 2;
  localparam int SRBD_ROW_OUT_W = 13;
  localparam int SRBD_PIN_W = 15;

  // terminal-count mask of the free prescaler for each select value
  function automatic logic [11:0] srbd_div_mask(input logic [2:0] sel);
    case (sel)
      3'h1: srbd_div_mask = 12'h003;
      3'h2: srbd_div_mask = 12'h00F;
      3'h3: srbd_div_mask = 12'h03F;
      3'h4: srbd_div_mask = 12'h0FF;
      3'h5: srbd_div_mask = 12'h3FF;
      3'h6: srbd_div_mask = 12'h7FF;
      3'h7: srbd_div_mask = 12'hFFF;
      default: srbd_div_mask = 12'h000;
    endcase
  endfunction

endpackage

// [test/srbd_sdram_model.sv]
// behavioural model of the sdram devices on the memory bus
`timescale 1ns/1ps
`default_nettype none
module srbd_sdram_model (
  input wire logic clock_in,
  input wire logic [14:0] sdram_addr_in,
  input wire logic mode_cmd_in,
  input wire logic refresh_cmd_in,
  input wire logic activate_block_in,
  output logic [9:0] mode_q_out,
  output int refresh_count_out,
  output int block_run_out
);
  int run_q;

  // ----------------------------------------------------------------
  // mode latch, refresh tally, activate hold-off length
  // ----------------------------------------------------------------
  // mode content stays unknown until the first load, as on real parts
  initial begin
    refresh_count_out = 0;
    block_run_out = 0;
    run_q = 0;
  end

  // the mode value is taken from the address pins, never the data lines
  always @(posedge clock_in) begin
    if (mode_cmd_in) mode_q_out <= sdram_addr_in[9:0];
    if (refresh_cmd_in) refresh_count_out <= refresh_count_out + 1;
    run_q <= activate_block_in ? run_q + 1 : 0;
    if (!activate_block_in && run_q != 0) block_run_out <= run_q;
  end
endmodule
`default_nettype wire

// [test/srbd_top_tb.sv]
// self-checking bench for the refresh, mode and bank decode block
`timescale 1ns/1ps
`default_nettype none
module srbd_top_tb;
  import srbd_pkg::*;
  logic clock_in, rst_b_in, reg_write_in, reg_read_in;
  logic row_phase_in, col_a10_in, mode_cmd_out, refresh_cmd_out;
  logic activate_block_out, bank_sel_out;
  logic [15:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, phys_addr_in, rd_v, r, a, mc;
  logic [14:0] sdram_addr_out;
  logic [9:0] mode_seen;
  int refresh_seen, block_run, num_errors, checks, cycles, n, c, refresh_cycle_time, d;
  logic [15:0] ra [6] = '{SRBD_OFS_CTRL_STATUS, SRBD_OFS_COUNT,
    SRBD_OFS_CONSTANT, SRBD_OFS_BANK_WINDOW, 16'h0020, SRBD_MODE_BASE};
  logic [31:0] re [6] = '{32'h0, 32'h0, 32'h0, 32'h000020F8, 32'h0, 32'h0};

  srbd_top i_srbd_top (.clock_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .phys_addr_in, .row_phase_in, .col_a10_in,
    .reg_rdata_out, .sdram_addr_out, .mode_cmd_out, .refresh_cmd_out,
    .activate_block_out, .bank_sel_out);

  srbd_sdram_model i_srbd_sdram_model (.clock_in,
    .sdram_addr_in(sdram_addr_out), .mode_cmd_in(mode_cmd_out),
    .refresh_cmd_in(refresh_cmd_out), .activate_block_in(activate_block_out),
    .mode_q_out(mode_seen), .refresh_count_out(refresh_seen),
    .block_run_out(block_run));

  // ----------------------------------------------------------------
  // clock, hang guard, helpers
  // ----------------------------------------------------------------
  // 25 MHz
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // slowest timer case needs about 8200 cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [15:0] ad, logic [31:0] dv);
    @(posedge clock_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= ad;
    reg_wdata_in <= dv;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(logic [15:0] ad, output logic [31:0] dv);
    @(posedge clock_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= ad;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 dv = reg_rdata_out;
  endtask

  // edges until the next refresh pulse, bounded
  task automatic wait_ref(int lim, output int k);
    k = 0;
    do begin
      @(posedge clock_in);
      #1 k++;
    end while (refresh_cmd_out !== 1'b1 && k < lim);
    if (k >= lim) chk("refresh wait", 32'h1, 32'h0);
  endtask

  function automatic int div_of(int s);
    return (s < 5) ? (1 << (2 * s)) : (1 << (s + 5));
  endfunction

  // expected pins: row or column on A12..A0, bank on A13/A14
  function automatic logic [14:0] mux(logic [31:0] p, logic [10:0] m,
      logic rp, logic a10);
    int cw, rw;
    logic [14:0] v;
    cw = m[7:5];
    rw = m[9:8];
    v[14] = m[10] & p[22 + cw + rw];
    v[13] = p[21 + cw + rw];
    v[12:0] = rp ? 13'(p >> (10 + cw)) : {p[13:12], a10, p[11:2]};
    return v;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_in = 1'b0;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    phys_addr_in = '0;
    row_phase_in = 1'b0;
    col_a10_in = 1'b0;
    num_errors = 0;
    checks = 0;
    cycles = 0;
    r = $urandom(32'h16F7);
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    // reset values, then refused and reserved places
    foreach (ra[i]) begin
      rd(ra[i], rd_v);
      chk("reset read", re[i], rd_v);
    end
    wr(SRBD_OFS_CTRL_STATUS, 32'hFFFFFF80);
    rd(SRBD_OFS_CTRL_STATUS, rd_v);
    chk("status reserved", 32'h0, rd_v);
    wr(16'h0020, 32'hFFFFFFFF);
    rd(16'h0020, rd_v);
    chk("unmapped", 32'h0, rd_v);
    for (int i = 1; i < 4; i++) begin
      r = $urandom;
      wr(16'(i * 4), r);
      rd(16'(i * 4), rd_v);
      chk("reg readback", {16'h0, r[15:0]}, rd_v);
    end
    // mode loads, corners first; data bus content is junk on purpose
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 0 : (i == 1) ? 1023 : $urandom_range(1023);
      wr(SRBD_MODE_BASE + 16'(c), $urandom);
      #1 chk("mode pulse", 32'h1, mode_cmd_out);
      chk("mode pins", c, sdram_addr_out);
      rd(SRBD_MODE_BASE + 16'(c), rd_v);
      chk("mode latched", c, mode_seen);
      chk("mode readback", 32'h0, rd_v);
    end
    // one window only, so regions cannot overlap
    for (int j = 0; j < 3; j++) begin
      mc = 32'(($urandom_range(1) << 10) | ($urandom_range(2) << 8)
        | ($urandom_range(4) << 5));
      wr(SRBD_OFS_MEM_CONTROL, mc);
      r = $urandom;
      r[15:8] = r[15:8] & r[7:0];
      wr(SRBD_OFS_BANK_WINDOW, r);
      for (int i = 0; i < 16; i++) begin
        a = $urandom;
        if (i[0]) a[31:24] = r[15:8] | (a[31:24] & ~r[7:0]);
        @(posedge clock_in);
        phys_addr_in <= a;
        row_phase_in <= a[0];
        col_a10_in <= a[1];
        @(posedge clock_in);
        #1 chk("bank select", 32'((a[31:24] & r[7:0]) == r[15:8]), bank_sel_out);
        chk("address pins", mux(a, mc[10:0], a[0], a[1]), sdram_addr_out);
      end
    end
    // every prescale ratio; constants carry junk in the upper byte
    for (int s = 1; s < 8; s++) begin
      c = (s == 1) ? 8 + $urandom_range(7) : (s == 2) ? 1 + $urandom_range(3)
        : (s < 5) ? $urandom_range(2) : 0;
      refresh_cycle_time = $urandom_range(7);
      d = div_of(s);
      r = $urandom;
      r[7:0] = 8'(c);
      wr(SRBD_OFS_CTRL_STATUS, 32'h0);
      wr(SRBD_OFS_CONSTANT, r);
      wr(SRBD_OFS_MEM_CONTROL, 32'((refresh_cycle_time << 2) | 1));
      wr(SRBD_OFS_COUNT, 32'h0);
      wr(SRBD_OFS_CTRL_STATUS, 32'(s));
      wait_ref((c + 3) * d, n);
      wait_ref((c + 3) * d, n);
      chk("refresh period", (c + 1) * d, n);
      rd(SRBD_OFS_CTRL_STATUS, rd_v);
      chk("match flag set", 32'h80 | s, rd_v);
      wr(SRBD_OFS_CTRL_STATUS, 32'h80);
      rd(SRBD_OFS_CTRL_STATUS, rd_v);
      chk("flag write one", 32'h80, rd_v);
      wr(SRBD_OFS_CTRL_STATUS, 32'h0);
      rd(SRBD_OFS_CTRL_STATUS, rd_v);
      chk("flag cleared", 32'h0, rd_v);
      repeat (34) @(posedge clock_in);
      chk("activate hold", 2 * refresh_cycle_time + 1, block_run);
    end
    // refresh off, then manual mode: flag sets, no refresh goes out
    for (int i = 0; i < 2; i++) begin
      wr(SRBD_OFS_CONSTANT, 32'h8);
      wr(SRBD_OFS_MEM_CONTROL, i ? 32'h3 : 32'h0);
      wr(SRBD_OFS_COUNT, 32'h0);
      n = refresh_seen;
      wr(SRBD_OFS_CTRL_STATUS, 32'h1);
      repeat (100) @(posedge clock_in);
      rd(SRBD_OFS_CTRL_STATUS, rd_v);
      chk("flag no refresh", 32'h81, rd_v);
      chk("refresh count", n, refresh_seen);
      wr(SRBD_OFS_CTRL_STATUS, 32'h0);
    end
    test_done();
  end
endmodule
`default_nettype wire
